/* hdl/tjm_cfg_defs.svh */
// Offsets, field positions, values and reset values of the T1/J1 mode configuration bank.
// Assumes register indices are word indices; byte address is index times four.
`ifndef TJM_CFG_DEFS_SVH
`define TJM_CFG_DEFS_SVH

`define TJM_NUM_FRAMERS 8
`define TJM_ADR_W 13
`define TJM_IDX_W 11
`define TJM_FRAMER_STRIDE 11'h080
`define TJM_GLOBAL_LIMIT 11'h400

// Per-framer register indices, framer 0
`define TJM_IDX_RX_BP_MODE 7'h01
`define TJM_IDX_RX_BP_PIN 7'h03
`define TJM_IDX_RX_RX_FRAME_PROCESSOR 7'h20
`define TJM_IDX_RX_RX_ALARM_DETECTOR 7'h2C
`define TJM_IDX_RX_SIGBUF 7'h40
`define TJM_IDX_TX_TX_FRAME_GENERATOR 7'h44
`define TJM_IDX_MODE_STATUS 7'h7F
// Global register index
`define TJM_IDX_GLOBAL_MODE 11'h400

// Field positions
`define TJM_TX_FRAME_GENERATOR_J1_FRAME_BIT 6
`define TJM_TX_FRAME_GENERATOR_J1_YELLOW_BIT 5
`define TJM_RX_FRAME_PROCESSOR_CRC_MIMIC_BIT 5
`define TJM_RX_FRAME_PROCESSOR_ESF_BIT 4
`define TJM_RX_FRAME_PROCESSOR_J1_BIT 3
`define TJM_RX_ALARM_DETECTOR_J1_BIT 5
`define TJM_RX_ALARM_DETECTOR_ESF_BIT 4
`define TJM_SIGBUF_ESF_BIT 2
`define TJM_GLOBAL_J1_BIT 0

// Backplane mode and pin configuration values
`define TJM_BP_SLAVE_REF 8'h80
`define TJM_BP_SLAVE_1544 8'hC0
`define TJM_BP_SLAVE_2048 8'hD0
`define TJM_BP_MASTER_FULL 8'h40
`define TJM_PIN_SLAVE 8'h13
`define TJM_PIN_MASTER 8'h10

// Reset values
`define TJM_CFG_RESET 8'h00
`define TJM_GLOBAL_RESET 8'h00

`endif

/* hdl/tjm_cfg_pkg.sv */
// Types of the T1/J1 mode configuration bank.
// Assumes tjm_cfg_defs.svh supplies the numeric constants.
package tjm_cfg_pkg;

	typedef enum logic [4:0] {
		TJM_RXM_NONE = 5'b00001,
		TJM_RXM_SLAVE_REF = 5'b00010,
		TJM_RXM_SLAVE_1544 = 5'b00100,
		TJM_RXM_SLAVE_2048 = 5'b01000,
		TJM_RXM_MASTER_FULL = 5'b10000
	} tjm_rx_mode_t;

	typedef enum logic [7:0] {
		TJM_SEL_NONE = 8'b00000001,
		TJM_SEL_BP_MODE = 8'b00000010,
		TJM_SEL_BP_PIN = 8'b00000100,
		TJM_SEL_RX_FRAME_PROCESSOR = 8'b00001000,
		TJM_SEL_RX_ALARM_DETECTOR = 8'b00010000,
		TJM_SEL_SIGBUF = 8'b00100000,
		TJM_SEL_TX_FRAME_GENERATOR = 8'b01000000,
		TJM_SEL_STATUS = 8'b10000000
	} tjm_reg_sel_t;

	typedef struct packed {
		tjm_rx_mode_t rxMode;
		logic j1Framing;
		logic framerEsf;
		logic crcOnMimic;
		logic alarmJ1;
		logic alarmEsf;
		logic sigBufEsf;
		logic dataOutEn;
		logic sigOutEn;
		logic updateOnRise;
		logic fpSampleFall;
		logic fpOutEn;
	} tjm_rx_cfg_t;

	typedef struct packed {
		logic j1FrameGen;
		logic j1YellowSend;
	} tjm_tx_cfg_t;

endpackage

/* hdl/tjm_cfg_bank.sv */
// T1/J1 mode configuration bank for eight framers, classic Wishbone slave.
// Assumes one clock, synchronous reset, yellowTxEn from logic on the same clock.
//
// Added by the designer: the Wishbone register port.
`include "tjm_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tjm_cfg_bank (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [`TJM_ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// Yellow alarm sending enable per framer
	input wire logic [`TJM_NUM_FRAMERS-1:0] yellowTxEn,
	// Decoded modes
	output logic globalJ1Mode,
	output tjm_cfg_pkg::tjm_rx_cfg_t [`TJM_NUM_FRAMERS-1:0] rxCfg,
	output tjm_cfg_pkg::tjm_tx_cfg_t [`TJM_NUM_FRAMERS-1:0] txCfg
);
	import tjm_cfg_pkg::*;

	logic [7:0] bpMode_reg [`TJM_NUM_FRAMERS];
	logic [7:0] bpPin_reg [`TJM_NUM_FRAMERS];
	logic [7:0] rx_frame_processor_reg [`TJM_NUM_FRAMERS];
	logic [7:0] rx_alarm_detector_reg [`TJM_NUM_FRAMERS];
	logic [7:0] sigBuf_reg [`TJM_NUM_FRAMERS];
	logic [7:0] tx_frame_generator_reg [`TJM_NUM_FRAMERS];
	logic [7:0] global_reg;
	logic ack_reg;
	logic [31:0] datR_reg;
	tjm_rx_cfg_t [`TJM_NUM_FRAMERS-1:0] rxCfg_reg;
	tjm_tx_cfg_t [`TJM_NUM_FRAMERS-1:0] txCfg_reg;
	logic [`TJM_IDX_W-1:0] idx;
	logic [2:0] framerSel;
	tjm_reg_sel_t regSel;
	logic isGlobal;
	logic busReq;
	logic wrEn;

	function automatic tjm_reg_sel_t decode_local(input logic [6:0] loc);
		tjm_reg_sel_t s;
		s = TJM_SEL_NONE;
		if (loc == `TJM_IDX_RX_BP_MODE) begin
			s = TJM_SEL_BP_MODE;
		end else if (loc == `TJM_IDX_RX_BP_PIN) begin
			s = TJM_SEL_BP_PIN;
		end else if (loc == `TJM_IDX_RX_RX_FRAME_PROCESSOR) begin
			s = TJM_SEL_RX_FRAME_PROCESSOR;
		end else if (loc == `TJM_IDX_RX_RX_ALARM_DETECTOR) begin
			s = TJM_SEL_RX_ALARM_DETECTOR;
		end else if (loc == `TJM_IDX_RX_SIGBUF) begin
			s = TJM_SEL_SIGBUF;
		end else if (loc == `TJM_IDX_TX_TX_FRAME_GENERATOR) begin
			s = TJM_SEL_TX_FRAME_GENERATOR;
		end else if (loc == `TJM_IDX_MODE_STATUS) begin
			s = TJM_SEL_STATUS;
		end
		return s;
	endfunction

	function automatic tjm_rx_mode_t decode_bp_mode(input logic [7:0] v);
		tjm_rx_mode_t m;
		m = TJM_RXM_NONE;
		if (v == `TJM_BP_SLAVE_REF) begin
			m = TJM_RXM_SLAVE_REF;
		end else if (v == `TJM_BP_SLAVE_1544) begin
			m = TJM_RXM_SLAVE_1544;
		end else if (v == `TJM_BP_SLAVE_2048) begin
			m = TJM_RXM_SLAVE_2048;
		end else if (v == `TJM_BP_MASTER_FULL) begin
			m = TJM_RXM_MASTER_FULL;
		end
		return m;
	endfunction

	// Address decode: framer in index bits 9:7, register in bits 6:0
	assign idx = wbAdr[`TJM_ADR_W-1:2];
	assign framerSel = idx[9:7];
	assign isGlobal = (idx == `TJM_IDX_GLOBAL_MODE);
	assign regSel = (idx < `TJM_GLOBAL_LIMIT) ? decode_local(idx[6:0]) : TJM_SEL_NONE;
	assign busReq = wbCyc && wbStb && !ack_reg;
	assign wrEn = busReq && wbWe && wbSel[0];

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= busReq;
		end
	end

	// Per-framer storage, only the addressed framer changes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < `TJM_NUM_FRAMERS; i++) begin
				bpMode_reg[i] <= `TJM_CFG_RESET;
				bpPin_reg[i] <= `TJM_CFG_RESET;
				rx_frame_processor_reg[i] <= `TJM_CFG_RESET;
				rx_alarm_detector_reg[i] <= `TJM_CFG_RESET;
				sigBuf_reg[i] <= `TJM_CFG_RESET;
				tx_frame_generator_reg[i] <= `TJM_CFG_RESET;
			end
		end else if (wrEn) begin
			case (regSel)
				TJM_SEL_BP_MODE: bpMode_reg[framerSel] <= wbDatW[7:0];
				TJM_SEL_BP_PIN: bpPin_reg[framerSel] <= wbDatW[7:0];
				TJM_SEL_RX_FRAME_PROCESSOR: rx_frame_processor_reg[framerSel] <= wbDatW[7:0];
				TJM_SEL_RX_ALARM_DETECTOR: rx_alarm_detector_reg[framerSel] <= wbDatW[7:0];
				TJM_SEL_SIGBUF: sigBuf_reg[framerSel] <= wbDatW[7:0];
				TJM_SEL_TX_FRAME_GENERATOR: tx_frame_generator_reg[framerSel] <= wbDatW[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			global_reg <= `TJM_GLOBAL_RESET;
		end else if (wrEn && isGlobal) begin
			global_reg <= wbDatW[7:0];
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			datR_reg <= 32'h0000_0000;
		end else if (busReq) begin
			datR_reg <= 32'h0000_0000;
			if (isGlobal) begin
				datR_reg[7:0] <= global_reg;
			end else begin
				case (regSel)
					TJM_SEL_BP_MODE: datR_reg[7:0] <= bpMode_reg[framerSel];
					TJM_SEL_BP_PIN: datR_reg[7:0] <= bpPin_reg[framerSel];
					TJM_SEL_RX_FRAME_PROCESSOR: datR_reg[7:0] <= rx_frame_processor_reg[framerSel];
					TJM_SEL_RX_ALARM_DETECTOR: datR_reg[7:0] <= rx_alarm_detector_reg[framerSel];
					TJM_SEL_SIGBUF: datR_reg[7:0] <= sigBuf_reg[framerSel];
					TJM_SEL_TX_FRAME_GENERATOR: datR_reg[7:0] <= tx_frame_generator_reg[framerSel];
					TJM_SEL_STATUS: datR_reg[4:0] <= rxCfg_reg[framerSel].rxMode;
					default: begin
					end
				endcase
			end
		end
	end

	// Receive mode decode per framer
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < `TJM_NUM_FRAMERS; i++) begin
				rxCfg_reg[i] <= '{rxMode: TJM_RXM_NONE, default: 1'b0};
			end
		end else begin
			for (int i = 0; i < `TJM_NUM_FRAMERS; i++) begin
				automatic tjm_rx_mode_t m = decode_bp_mode(bpMode_reg[i]);
				automatic logic slave = (m == TJM_RXM_SLAVE_REF) || (m == TJM_RXM_SLAVE_1544)
					|| (m == TJM_RXM_SLAVE_2048);
				automatic logic slvPins = slave && (bpPin_reg[i] == `TJM_PIN_SLAVE);
				automatic logic mstPins = (m == TJM_RXM_MASTER_FULL)
					&& (bpPin_reg[i] == `TJM_PIN_MASTER);
				rxCfg_reg[i].rxMode <= m;
				rxCfg_reg[i].j1Framing <= rx_frame_processor_reg[i][`TJM_RX_FRAME_PROCESSOR_J1_BIT];
				rxCfg_reg[i].framerEsf <= rx_frame_processor_reg[i][`TJM_RX_FRAME_PROCESSOR_ESF_BIT];
				rxCfg_reg[i].crcOnMimic <= rx_frame_processor_reg[i][`TJM_RX_FRAME_PROCESSOR_CRC_MIMIC_BIT];
				rxCfg_reg[i].alarmJ1 <= rx_alarm_detector_reg[i][`TJM_RX_ALARM_DETECTOR_J1_BIT];
				rxCfg_reg[i].alarmEsf <= rx_alarm_detector_reg[i][`TJM_RX_ALARM_DETECTOR_ESF_BIT];
				rxCfg_reg[i].sigBufEsf <= sigBuf_reg[i][`TJM_SIGBUF_ESF_BIT];
				rxCfg_reg[i].dataOutEn <= slvPins || mstPins;
				rxCfg_reg[i].sigOutEn <= slvPins && (m != TJM_RXM_SLAVE_REF);
				rxCfg_reg[i].updateOnRise <= slvPins || mstPins;
				rxCfg_reg[i].fpSampleFall <= slvPins;
				rxCfg_reg[i].fpOutEn <= mstPins;
			end
		end
	end

	// Transmit decode per framer
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < `TJM_NUM_FRAMERS; i++) begin
				txCfg_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < `TJM_NUM_FRAMERS; i++) begin
				txCfg_reg[i].j1FrameGen <= tx_frame_generator_reg[i][`TJM_TX_FRAME_GENERATOR_J1_FRAME_BIT];
				txCfg_reg[i].j1YellowSend <= tx_frame_generator_reg[i][`TJM_TX_FRAME_GENERATOR_J1_YELLOW_BIT]
					&& yellowTxEn[i];
			end
		end
	end

	logic globalJ1_reg;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			globalJ1_reg <= 1'b0;
		end else begin
			globalJ1_reg <= global_reg[`TJM_GLOBAL_J1_BIT];
		end
	end

	assign wbAck = ack_reg;
	assign wbDatR = datR_reg;
	assign rxCfg = rxCfg_reg;
	assign txCfg = txCfg_reg;
	assign globalJ1Mode = globalJ1_reg;

	// Checks
	AST_ACK_ONE: assert property (@(posedge clk_sys) disable iff (srst)
		(wbCyc && wbStb && !wbAck) |=> wbAck ##1 !wbAck)
		else $error("ack not a single cycle after request");
	AST_J1_FRAME: assert property (@(posedge clk_sys) disable iff (srst)
		##1 txCfg[0].j1FrameGen == $past(tx_frame_generator_reg[0][6]))
		else $error("framer 0 J1 frame select not followed");
	AST_J1_YELLOW: assert property (@(posedge clk_sys) disable iff (srst)
		txCfg[2].j1YellowSend |-> $past(yellowTxEn[2]) && $past(tx_frame_generator_reg[2][5]))
		else $error("J1 yellow sent without enable");
	AST_ALARM_J1: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(rx_alarm_detector_reg[5][5]) |=> rxCfg[5].alarmJ1)
		else $error("alarm detector J1 not taken");
	AST_STRIDE: assert property (@(posedge clk_sys) disable iff (srst)
		(wrEn && wbAdr == 13'h0510) |=> tx_frame_generator_reg[2] == $past(wbDatW[7:0]))
		else $error("framer 2 generator write misplaced");
	AST_SLAVE_1544: assert property (@(posedge clk_sys) disable iff (srst)
		(bpMode_reg[3] == 8'hC0) ##1 (bpMode_reg[3] == 8'hC0)
		|-> rxCfg[3].rxMode == TJM_RXM_SLAVE_1544)
		else $error("1.544 slave mode not decoded");
	AST_MASTER: assert property (@(posedge clk_sys) disable iff (srst)
		(bpMode_reg[3] == 8'h40) |=> rxCfg[3].rxMode == TJM_RXM_MASTER_FULL)
		else $error("master mode not decoded");
	AST_SLAVE_PINS: assert property (@(posedge clk_sys) disable iff (srst)
		rxCfg[3].fpSampleFall |-> rxCfg[3].updateOnRise && !rxCfg[3].fpOutEn
		&& $past(bpPin_reg[3]) == 8'h13)
		else $error("slave pin behaviour wrong");
	AST_MASTER_PINS: assert property (@(posedge clk_sys) disable iff (srst)
		rxCfg[3].fpOutEn |-> rxCfg[3].dataOutEn && rxCfg[3].rxMode == TJM_RXM_MASTER_FULL)
		else $error("master pin behaviour wrong");
	AST_ESF: assert property (@(posedge clk_sys) disable iff (srst)
		(rx_frame_processor_reg[3] == 8'h30) |=> rxCfg[3].framerEsf && rxCfg[3].crcOnMimic)
		else $error("frame processor ESF not decoded");
	AST_SF: assert property (@(posedge clk_sys) disable iff (srst)
		(rx_alarm_detector_reg[2] == 8'h00 && sigBuf_reg[2] == 8'h00)
		|=> !rxCfg[2].alarmEsf && !rxCfg[2].sigBufEsf)
		else $error("SF not decoded");
	AST_GLOBAL: assert property (@(posedge clk_sys) disable iff (srst)
		$rose(global_reg[0]) |=> globalJ1Mode)
		else $error("global J1 mode not followed");
	AST_ISOLATE: assert property (@(posedge clk_sys) disable iff (srst)
		(wrEn && framerSel != 3'h1) |=> $stable(bpMode_reg[1]))
		else $error("other framer register changed");
	COV_SLAVE_REF: cover property (@(posedge clk_sys) rxCfg[3].rxMode == TJM_RXM_SLAVE_REF);
	COV_SLAVE_2048: cover property (@(posedge clk_sys) rxCfg[3].rxMode == TJM_RXM_SLAVE_2048);
	COV_MASTER_PINS: cover property (@(posedge clk_sys) rxCfg[3].fpOutEn);
	COV_YELLOW: cover property (@(posedge clk_sys) txCfg[0].j1YellowSend);

endmodule // tjm_cfg_bank
`default_nettype wire

/* sim/tjm_yellow_src.sv */
// Far-side model: logic on the same clock that enables yellow alarm sending per framer.
// Assumes the bench asks for a new enable pattern through yellowReq.
`timescale 1ns/1ps
`default_nettype none
module tjm_yellow_src (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Request from the bench and enable towards the bank
	input wire logic [7:0] yellowReq,
	output logic [7:0] yellowTxEn
);
	// Registered, as real alarm logic would be
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			yellowTxEn <= 8'h00;
		end else begin
			yellowTxEn <= yellowReq;
		end
	end
endmodule // tjm_yellow_src
`default_nettype wire

/* sim/test_t1_j1_mode_config_decode.sv */
// Self-checking bench of the T1/J1 mode configuration bank.
// Assumes the package, the bank and tjm_yellow_src are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_t1_j1_mode_config_decode;
	import tjm_cfg_pkg::*;
	logic clk_sys, srst, wbCyc, wbStb, wbWe, wbAck, globalJ1Mode;
	logic [12:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatW, wbDatR;
	logic [7:0] yellowReq, yellowTxEn;
	tjm_rx_cfg_t [7:0] rxCfg;
	tjm_tx_cfg_t [7:0] txCfg;
	int fails, check_count, cycles;

	tjm_cfg_bank dut_u (.clk_sys(clk_sys), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
		.wbAck(wbAck), .yellowTxEn(yellowTxEn), .globalJ1Mode(globalJ1Mode),
		.rxCfg(rxCfg), .txCfg(txCfg));
	tjm_yellow_src far_u (.clk_sys(clk_sys), .srst(srst), .yellowReq(yellowReq),
		.yellowTxEn(yellowTxEn));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			$display("BAD %0t timeout", $time);
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	// Classic single cycle; waits for ack, then releases
	task automatic xfer(input logic we, input int f, input int i, input logic [7:0] d,
		input logic s, output logic [31:0] r);
		int n;
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= 13'((f * 128 + i) * 4);
		wbDatW <= {24'h000000, d};
		wbSel <= {3'h7, s};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		r = wbDatR;
		if (n >= 50) chk(32'h0, 32'h1, "no ack");
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input int f, input int i, input logic [7:0] d, input logic s = 1'b1);
		logic [31:0] r;
		xfer(1'b1, f, i, d, s, r);
	endtask

	task automatic rd(input int f, input int i, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, f, i, 8'h00, 1'b1, r);
		chk(r, e, "read");
	endtask

	function automatic tjm_rx_cfg_t expRx(input logic [7:0] bp, pin, fp, al, sb);
		tjm_rx_cfg_t e;
		logic sl;
		e = '0;
		e.rxMode = bp == 8'h80 ? TJM_RXM_SLAVE_REF : bp == 8'hC0 ? TJM_RXM_SLAVE_1544 :
			bp == 8'hD0 ? TJM_RXM_SLAVE_2048 : bp == 8'h40 ? TJM_RXM_MASTER_FULL : TJM_RXM_NONE;
		sl = e.rxMode inside {TJM_RXM_SLAVE_REF, TJM_RXM_SLAVE_1544, TJM_RXM_SLAVE_2048};
		e.fpSampleFall = sl && pin == 8'h13;
		e.sigOutEn = e.fpSampleFall && bp[6];
		e.fpOutEn = bp == 8'h40 && pin == 8'h10;
		e.dataOutEn = e.fpSampleFall || e.fpOutEn;
		e.updateOnRise = e.dataOutEn;
		{e.crcOnMimic, e.framerEsf, e.j1Framing} = fp[5:3];
		{e.alarmJ1, e.alarmEsf} = al[5:4];
		e.sigBufEsf = sb[2];
		return e;
	endfunction

	task automatic testReset();
		for (int f = 0; f < 8; f++) begin
			chk(32'(rxCfg[f]), 32'(expRx(0, 0, 0, 0, 0)), "reset rx");
			rd(f, 'h44, 32'h0);
		end
		chk(32'(txCfg), 32'h0, "reset tx");
		chk(32'(globalJ1Mode), 32'h0, "reset global");
		$display("test reset done");
	endtask

	task automatic testJ1();
		logic [15:0] et;
		et = '0;
		for (int f = 0; f < 8; f++) begin
			wr(f, 'h44, 8'h60);
			wr(f, 'h20, 8'h08);
			wr(f, 'h2C, 8'h20);
			et[2 * f + 1] = 1'b1;
			chk(32'(txCfg), 32'(et), "tx j1");
			chk(32'(rxCfg[f]), 32'(expRx(0, 0, 8'h08, 8'h20, 0)), "rx j1");
		end
		yellowReq <= 8'hA5;
		repeat (3) @(posedge clk_sys);
		chk(32'(txCfg), 32'hEEBB, "yellow on");
		yellowReq <= 8'h00;
		repeat (3) @(posedge clk_sys);
		chk(32'(txCfg), 32'(et), "yellow off");
		wr(0, 'h400, 8'h01);
		chk(32'(globalJ1Mode), 32'h1, "global");
		rd(0, 'h400, 32'h1);
		wr(0, 'h400, 8'h00);
		chk(32'(globalJ1Mode), 32'h0, "global off");
		$display("test j1 done");
	endtask

	task automatic testModes();
		logic [7:0] t[6][5] = '{'{8'h80, 8'h13, 8'h30, 8'h10, 8'h04},
			'{8'hC0, 8'h13, 8'h30, 8'h10, 8'h04}, '{8'hD0, 8'h13, 8'h30, 8'h10, 8'h04},
			'{8'h40, 8'h10, 8'h00, 8'h00, 8'h00}, '{8'h40, 8'h13, 8'h30, 8'h00, 8'h00},
			'{8'h55, 8'h13, 8'h00, 8'h10, 8'h04}};
		tjm_rx_cfg_t e;
		for (int k = 0; k < 6; k++) begin
			wr(3, 'h01, t[k][0]);
			wr(3, 'h03, t[k][1]);
			wr(3, 'h20, t[k][2]);
			wr(3, 'h2C, t[k][3]);
			wr(3, 'h40, t[k][4]);
			e = expRx(t[k][0], t[k][1], t[k][2], t[k][3], t[k][4]);
			chk(32'(rxCfg[3]), 32'(e), "mode");
			rd(3, 'h01, 32'(t[k][0]));
			rd(3, 'h7F, 32'(e.rxMode));
			chk(32'(rxCfg[2]), 32'(expRx(0, 0, 8'h08, 8'h20, 0)), "neighbour");
		end
		$display("test modes done");
	endtask

	task automatic testBus();
		wr(1, 'h10, 8'hFF);
		rd(1, 'h10, 32'h0);
		wr(5, 'h44, 8'h00, 1'b0);
		chk(32'(txCfg[5]), 32'h2, "sel ignored");
		wr(5, 'h7F, 8'hFF);
		rd(5, 'h7F, 32'h1);
		$display("test bus done");
	endtask

	task complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		srst = 1'b1;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = '0;
		wbSel = 4'h0;
		wbDatW = '0;
		yellowReq = 8'h00;
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		testReset();
		testJ1();
		testModes();
		testBus();
		complete_run();
	end
endmodule // test_t1_j1_mode_config_decode
`default_nettype wire
